// [common/ldsc_params.svh]
// Purpose: Offsets, field positions, reset values of the laser driver status block
// Assumes: 8-bit registers, 6-bit register address
// Notes: Definitions only
`ifndef LDSC_PARAMS_SVH
`define LDSC_PARAMS_SVH

// Register offsets
`define LDSC_OFS_EVENT_FLAGS 6'h00
`define LDSC_OFS_CHANNEL_FLAGS 6'h01
`define LDSC_OFS_DIE_TEMP 6'h02
`define LDSC_OFS_CONV1_HIGH 6'h03
`define LDSC_OFS_CONV1_LOW 6'h04
`define LDSC_OFS_CONV2_HIGH 6'h05
`define LDSC_OFS_CONV2_LOW 6'h06
`define LDSC_OFS_REVISION 6'h0F
`define LDSC_OFS_CH1_CONTROL 6'h10

// Event flag positions
`define LDSC_B_MEM_INIT 0
`define LDSC_B_CORE_DROP 1
`define LDSC_B_CFG_INTEGRITY 2
`define LDSC_B_OVER_TEMP 3
`define LDSC_B_CH2_OVC 4
`define LDSC_B_CH1_OVC 5
`define LDSC_B_OSC_FAULT 6
`define LDSC_B_SETUP_TIMEOUT 7

// Channel flag positions
`define LDSC_B_CH1_LEVEL 0
`define LDSC_B_CH1_SEEN 1
`define LDSC_B_CH1_SAT 2
`define LDSC_B_CH1_SUPPLY 3
`define LDSC_B_CH2_LEVEL 4
`define LDSC_B_CH2_SEEN 5
`define LDSC_B_CH2_SAT 6
`define LDSC_B_CH2_SUPPLY 7

// Channel one control field positions
`define LDSC_B_CURRENT_MODE 0
`define LDSC_B_EXT_CAP 1
`define LDSC_B_RES_OFF 2
`define LDSC_B_SOFT_DIS 3
`define LDSC_B_OFFSET_COMP 4

// Reset values
`define LDSC_RST_CH1_CONTROL 8'h18
`define LDSC_RST_FLAGS 8'h00
`define LDSC_REVISION_DEFAULT 8'h01

`endif

// [common/ldsc_pkg.sv]
// Purpose: Types shared by the laser driver status block
// Assumes: Constants live in ldsc_params.svh
// Notes: Event struct order is fixed, msb first
package ldsc_pkg;

    // Raw event and pin levels from the analog side
    typedef struct packed {
        logic mem_init;
        logic core_drop;
        logic cfg_dirty;
        logic over_temp;
        logic ch1_ovc;
        logic ch2_ovc;
        logic osc_fault;
        logic cfg_mode;
        logic cfg_timeout;
        logic ch1_enable_pin;
        logic ch2_enable_pin;
        logic ch1_sat;
        logic ch2_sat;
        logic ch1_supply_drop;
        logic ch2_supply_drop;
        logic supply_mismatch;
    } ldsc_evt_t;

    // Channel one control fields
    typedef struct packed {
        logic offset_comp_en;
        logic soft_disable;
        logic internal_resistor_off;
        logic ext_integrator_cap;
        logic current_mode_sel;
    } ldsc_ctrl_t;

endpackage

// [hw/ldsc_regs.sv]
// Purpose: Status, measurement and channel one control registers of the laser driver
// Assumes: Register port is a simple strobe port behind the serial decoder, same clock
// Notes: Read data lands one cycle after the read strobe; flags clear on that same edge
//
// How it works
// [R01] Memory-init flag, bit 0 of event flags, set on init, cleared on read.
// [R02] Core supply drop latches in bit 1, cleared on read.
// [R03] Bit 2 reads 1 while configuration changed and not validated.
// [R04] Overtemperature latches in bit 3, cleared on read.
// [R05] Overcurrent flags: channel one bit 5, channel two bit 4, clear on read.
// [R06] Oscillator watchdog fault latches in bit 6, cleared on read.
// [R07] Bit 7 is config mode and timeout; lasers are then switched off.
// [R08] Channel flags bits 0 and 4 show live enable pin levels.
// [R09] Bits 1 and 5 latch enable pin seen high, clear on read.
// [R10] Bits 2 and 6 latch output saturation, clear on read.
// [R11] Bit 3 latches channel one supply drop, or supply mismatch when merged.
// [R12] Bit 7 latches channel two drop, or either drop when merged.
// [R13] Die temperature reads at 0x02 as 8 bits.
// [R14] Channel one result: bits 9:8 at 0x03, bits 7:0 at 0x04.
// [R15] Channel two result: bits 9:8 at 0x05, bits 7:0 at 0x06.
// [R16] Revision code reads at 0x0F.
// [R17] Control bit 0 picks current regulation when 1, power regulation at 0.
// [R18] Control bit 1 connects the external integrator capacitor, resets to 0.
// [R19] Control bit 2 switches off the internal monitor resistor when 1.
// [R20] Control bit 3 resets to 1 and blocks the enable pin while set.
// [R21] Control bit 4 resets to 1 and enables offset compensation.
// [R22] Fault output asserts while any unmasked status flag is set.
// [R23] A read clears only what it returned; events during it stay latched.
`include "ldsc_params.svh"

module ldsc_regs #(
    parameter logic [7:0] REVISION_CODE = `LDSC_REVISION_DEFAULT  // Arbitrary value
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Asynchronous events and pins
    input wire ldsc_pkg::ldsc_evt_t events_i,
    input wire logic merge_i,
    // Measurements from on-chip converters, same clock
    input wire logic [7:0] die_temperature_i,
    input wire logic [9:0] ch1_conversion_result_i,
    input wire logic [9:0] ch2_conversion_result_i,
    // Fault masks, bit 15:8 channel flags, 7:0 event flags
    input wire logic [15:0] fault_mask_i,
    // Channel one controls and outputs
    output ldsc_pkg::ldsc_ctrl_t ch1_ctrl_o,
    output logic ch1_drive_en_o,
    output logic ch2_laser_allow_o,
    output logic fault_out_n_o
);

    // Two-stage synchroniser for everything arriving from the pins
    ldsc_pkg::ldsc_evt_t sync_a;
    ldsc_pkg::ldsc_evt_t ev;
    logic merge_a;
    logic merge;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_a <= '0;
            ev <= '0;
            merge_a <= 1'b0;
            merge <= 1'b0;
        end else begin
            sync_a <= events_i;
            ev <= sync_a;
            merge_a <= merge_i;
            merge <= merge_a;
        end
    end

    // Register state
    logic [7:0] event_flags;
    logic [7:0] channel_flags;
    ldsc_pkg::ldsc_ctrl_t ctrl;
    logic [7:0] rdata;
    logic rvalid;
    logic drive_en;
    logic ch2_allow;
    logic fault_n;
    logic [7:0] next_event_flags;
    logic [7:0] next_channel_flags;
    ldsc_pkg::ldsc_ctrl_t next_ctrl;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_drive_en;
    logic next_ch2_allow;
    logic next_fault_n;

    // Live levels that are not latched
    logic timeout_live;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] view0;
    logic [7:0] view1;

    // Control reset image; only the low five bits are held here
    localparam logic [7:0] CTRL_RESET = `LDSC_RST_CH1_CONTROL;

    // Address match shared by clear logic and control write
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Event sources; the set term is always ORed after the clear
    always_comb begin
        timeout_live = ev.cfg_mode & ev.cfg_timeout; // R07
        set0 = '0;
        set0[`LDSC_B_MEM_INIT] = ev.mem_init; // R01
        set0[`LDSC_B_CORE_DROP] = ev.core_drop; // R02
        set0[`LDSC_B_OVER_TEMP] = ev.over_temp; // R04
        set0[`LDSC_B_CH2_OVC] = ev.ch2_ovc; // R05
        set0[`LDSC_B_CH1_OVC] = ev.ch1_ovc; // R05
        set0[`LDSC_B_OSC_FAULT] = ev.osc_fault; // R06
        set1 = '0;
        set1[`LDSC_B_CH1_SEEN] = ev.ch1_enable_pin; // R09
        set1[`LDSC_B_CH2_SEEN] = ev.ch2_enable_pin; // R09
        set1[`LDSC_B_CH1_SAT] = ev.ch1_sat; // R10
        set1[`LDSC_B_CH2_SAT] = ev.ch2_sat; // R10
        // Merged channels watch the pair of supplies instead
        set1[`LDSC_B_CH1_SUPPLY] = merge ? ev.supply_mismatch : ev.ch1_supply_drop; // R11
        set1[`LDSC_B_CH2_SUPPLY] = merge ? (ev.ch1_supply_drop | ev.ch2_supply_drop)
                                         : ev.ch2_supply_drop; // R12
    end

    // What a read returns: latched bits merged with live levels
    always_comb begin
        view0 = event_flags;
        view0[`LDSC_B_CFG_INTEGRITY] = ev.cfg_dirty; // R03
        view0[`LDSC_B_SETUP_TIMEOUT] = timeout_live; // R07
        view1 = channel_flags;
        view1[`LDSC_B_CH1_LEVEL] = ev.ch1_enable_pin; // R08
        view1[`LDSC_B_CH2_LEVEL] = ev.ch2_enable_pin; // R08
    end

    // Flag update: clear what was returned, then add fresh events
    always_comb begin
        next_event_flags = event_flags;
        next_channel_flags = channel_flags;
        if (reg_rd_i && hit(reg_addr_i, `LDSC_OFS_EVENT_FLAGS)) begin
            next_event_flags = event_flags & ~event_flags; // R23
        end
        if (reg_rd_i && hit(reg_addr_i, `LDSC_OFS_CHANNEL_FLAGS)) begin
            next_channel_flags = channel_flags & ~channel_flags; // R23
        end
        // Live positions never hold latched state
        next_event_flags = (next_event_flags | set0) & 8'h7B; // R23
        next_channel_flags = (next_channel_flags | set1) & 8'hEE; // R23
    end

    // Read mux; bits above each field read as zero
    always_comb begin
        next_rdata = rdata;
        next_rvalid = reg_rd_i;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LDSC_OFS_EVENT_FLAGS: next_rdata = view0;
                `LDSC_OFS_CHANNEL_FLAGS: next_rdata = view1;
                `LDSC_OFS_DIE_TEMP: next_rdata = die_temperature_i; // R13
                `LDSC_OFS_CONV1_HIGH: next_rdata = {6'h00, ch1_conversion_result_i[9:8]}; // R14
                `LDSC_OFS_CONV1_LOW: next_rdata = ch1_conversion_result_i[7:0]; // R14
                `LDSC_OFS_CONV2_HIGH: next_rdata = {6'h00, ch2_conversion_result_i[9:8]}; // R15
                `LDSC_OFS_CONV2_LOW: next_rdata = ch2_conversion_result_i[7:0]; // R15
                `LDSC_OFS_REVISION: next_rdata = REVISION_CODE; // R16
                `LDSC_OFS_CH1_CONTROL: next_rdata = {3'h0, ctrl};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Control register; bits 7:5 of a write are not held here
    always_comb begin
        next_ctrl = ctrl;
        if (reg_wr_i && hit(reg_addr_i, `LDSC_OFS_CH1_CONTROL)) begin
            next_ctrl.current_mode_sel = reg_wdata_i[`LDSC_B_CURRENT_MODE]; // R17
            next_ctrl.ext_integrator_cap = reg_wdata_i[`LDSC_B_EXT_CAP]; // R18
            next_ctrl.internal_resistor_off = reg_wdata_i[`LDSC_B_RES_OFF]; // R19
            next_ctrl.soft_disable = reg_wdata_i[`LDSC_B_SOFT_DIS]; // R20
            next_ctrl.offset_comp_en = reg_wdata_i[`LDSC_B_OFFSET_COMP]; // R21
        end
    end

    // Laser gating and fault pin; timeout wins over any enable
    always_comb begin
        next_drive_en = ev.ch1_enable_pin & ~ctrl.soft_disable & ~timeout_live; // R20 R07
        next_ch2_allow = ~timeout_live; // R07
        // Active low so several devices can share a wired interrupt line
        next_fault_n = ~(|({view1, view0} & ~fault_mask_i)); // R22
    end

    // State registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            event_flags <= `LDSC_RST_FLAGS;
            channel_flags <= `LDSC_RST_FLAGS;
            ctrl <= ldsc_pkg::ldsc_ctrl_t'(CTRL_RESET[4:0]); // R20 R21
            rdata <= 8'h00;
            rvalid <= 1'b0;
            drive_en <= 1'b0;
            ch2_allow <= 1'b0;
            fault_n <= 1'b1;
        end else begin
            event_flags <= next_event_flags;
            channel_flags <= next_channel_flags;
            ctrl <= next_ctrl;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            drive_en <= next_drive_en;
            ch2_allow <= next_ch2_allow;
            fault_n <= next_fault_n;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o = rdata;
    assign reg_rvalid_o = rvalid;
    assign ch1_ctrl_o = ctrl;
    assign ch1_drive_en_o = drive_en;
    assign ch2_laser_allow_o = ch2_allow;
    assign fault_out_n_o = fault_n;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    mem_init_latch_a: assert property (ev.mem_init |=> event_flags[`LDSC_B_MEM_INIT]) // R01
        else $error("memory init event not latched");

    event_clear_a: assert property (
        (reg_rd_i && reg_addr_i == `LDSC_OFS_EVENT_FLAGS && !ev.core_drop)
        |=> !event_flags[`LDSC_B_CORE_DROP] && reg_rdata_o[`LDSC_B_CORE_DROP]
            == $past(event_flags[`LDSC_B_CORE_DROP])) // R02
        else $error("core drop flag not returned and cleared");

    integrity_live_a: assert property (
        (reg_rd_i && reg_addr_i == `LDSC_OFS_EVENT_FLAGS)
        |=> reg_rdata_o[`LDSC_B_CFG_INTEGRITY] == $past(ev.cfg_dirty)) // R03
        else $error("integrity bit not live");

    ovc_held_a: assert property (
        (ev.ch1_ovc && !reg_rd_i) ##1 (!reg_rd_i)[*2]
        |-> event_flags[`LDSC_B_CH1_OVC]) // R05
        else $error("overcurrent flag lost without a read");

    timeout_off_a: assert property (
        (ev.cfg_mode && ev.cfg_timeout) |=> !ch1_drive_en_o && !ch2_laser_allow_o) // R07
        else $error("laser not switched off on setup timeout");

    soft_dis_a: assert property (ctrl.soft_disable |=> !ch1_drive_en_o) // R20
        else $error("soft disable did not block channel one");

    pin_level_a: assert property (
        (reg_rd_i && reg_addr_i == `LDSC_OFS_CHANNEL_FLAGS)
        |=> reg_rdata_o[`LDSC_B_CH2_LEVEL] == $past(ev.ch2_enable_pin)) // R08
        else $error("enable pin level not reported live");

    merge_supply_a: assert property (
        (merge && ev.supply_mismatch) |=> channel_flags[`LDSC_B_CH1_SUPPLY]) // R11
        else $error("supply mismatch not latched when merged");

    read_race_a: assert property (
        (reg_rd_i && reg_addr_i == `LDSC_OFS_CHANNEL_FLAGS && ev.ch1_sat)
        |=> channel_flags[`LDSC_B_CH1_SAT]) // R23
        else $error("event during read was lost");

    conv_read_a: assert property (
        (reg_rd_i && reg_addr_i == `LDSC_OFS_CONV1_HIGH)
        |=> reg_rvalid_o && reg_rdata_o == {6'h00, $past(ch1_conversion_result_i[9:8])}) // R14
        else $error("converter high byte wrong");

    fault_pin_a: assert property (
        (|({view1, view0} & ~fault_mask_i)) |=> !fault_out_n_o) // R22
        else $error("fault pin idle with unmasked flag");

endmodule

// [bench/ldsc_host_model.sv]
// Purpose: Host microcontroller model on the register strobe port
// Assumes: Strobes launched on falling edges, one cycle each
// Notes: Released address and data are inverted so stale values never pass as valid
module ldsc_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Register port towards the device
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [5:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port at time zero
    initial begin
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_addr_o = 6'h3F;
        reg_wdata_o = 8'hA5;
    end

    // One strobe cycle, then release with a scrambled bus
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_rd_o <= ~wr;
        reg_wr_o <= wr;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(negedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench of the laser driver status registers
// Assumes: Host model drives the strobe port on falling edges
// Notes: Read expectations are queued and checked when read data returns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV = 8'h5A;  // Arbitrary value
    logic ref_clk_i, sys_rst_i, merge_i, reg_rd_i, reg_wr_i, reg_rvalid_o;
    logic drive_en, ch2_allow, fault_n;
    logic [5:0] reg_addr_i, mon_adr;
    logic [7:0] reg_wdata_i, reg_rdata_o, temp, mon_exp, d;
    logic [9:0] conv1, conv2;
    logic [15:0] mask;
    ldsc_pkg::ldsc_evt_t ev;
    ldsc_pkg::ldsc_ctrl_t ctrl;
    logic [7:0] exp_q[$];
    logic [5:0] adr_q[$];
    int bad_count = 0;
    int checks = 0;
    integer seed = 32'hc4a2;
    // Event table: struct bit, register, expected flags, merge
    localparam int EB[16] = '{15, 14, 12, 11, 10, 9, 6, 5, 4, 3, 2, 1, 0, 2, 1, 0};
    localparam logic [5:0] EA[16] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    localparam logic [7:0] EX[16] = '{8'h01, 8'h02, 8'h08, 8'h20, 8'h10, 8'h40, 8'h02,
        8'h20, 8'h04, 8'h40, 8'h08, 8'h80, 8'h00, 8'h80, 8'h80, 8'h08};
    localparam logic EM[16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1};

    // 40 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    ldsc_regs #(.REVISION_CODE(REV)) u_ldsc_regs (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i),
        .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .events_i(ev),
        .merge_i(merge_i), .die_temperature_i(temp), .ch1_conversion_result_i(conv1),
        .ch2_conversion_result_i(conv2), .fault_mask_i(mask), .ch1_ctrl_o(ctrl),
        .ch1_drive_en_o(drive_en), .ch2_laser_allow_o(ch2_allow), .fault_out_n_o(fault_n)
    );

    ldsc_host_model u_host (
        .ref_clk_i(ref_clk_i), .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i)
    );

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Read with its expectation queued first
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        u_host.access(1'b0, a, 8'h00);
    endtask

    task automatic report_and_stop();
        // A read that never returned data is a mismatch too
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("[FAIL] pending reads expected 0 seen %0d", exp_q.size());
        end
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Read data checked in order against the queued notes
    always @(negedge ref_clk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("[FAIL] rdata expected none seen %h", reg_rdata_o);
            end else begin
                mon_exp = exp_q.pop_front();
                mon_adr = adr_q.pop_front();
                `CHK($sformatf("rdata at %h", mon_adr), mon_exp, reg_rdata_o)
            end
        end
    end

    // Hang guard, far beyond the expected run length
    initial begin
        wait_n(5000);
        bad_count++;
        report_and_stop();
    end

    initial begin
        sys_rst_i = 1'b1;
        merge_i = 1'b0;
        ev = '0;
        mask = 16'h0000;
        temp = 8'h00;
        conv1 = 10'h000;
        conv2 = 10'h000;
        wait_n(3);
        `CHK("ctrl reset", 5'h18, ctrl)
        `CHK("fault reset", 1'b1, fault_n)
        sys_rst_i = 1'b0;
        rdc(6'h10, 8'h18);
        // One-cycle event pulses, read twice: expected flags, then zero
        for (int i = 0; i < 16; i++) begin
            merge_i = EM[i];
            wait_n(3);
            `CHK("fault idle", 1'b1, fault_n)
            ev[EB[i]] = 1'b1;
            wait_n(1);
            ev[EB[i]] = 1'b0;
            wait_n(4);
            `CHK("fault", EX[i] == 8'h00, fault_n)
            rdc(EA[i], EX[i]);
            rdc(EA[i], 8'h00);
        end
        // A masked flag must not reach the fault pin
        merge_i = 1'b0;
        mask = 16'h0008;
        ev[12] = 1'b1;
        wait_n(1);
        ev[12] = 1'b0;
        wait_n(4);
        `CHK("fault masked", 1'b1, fault_n)
        rdc(6'h00, 8'h08);
        mask = 16'h0000;
        // Enable pins held high, then setup timeout and dirty configuration
        u_host.access(1'b1, 6'h10, 8'h00);
        ev[6] = 1'b1;
        ev[5] = 1'b1;
        wait_n(5);
        `CHK("drive on", 1'b1, drive_en)
        `CHK("ch2 allow", 1'b1, ch2_allow)
        rdc(6'h01, 8'h33);
        rdc(6'h01, 8'h33);
        ev[8] = 1'b1;
        ev[7] = 1'b1;
        ev[13] = 1'b1;
        wait_n(4);
        rdc(6'h00, 8'h84);
        `CHK("drive timeout", 1'b0, drive_en)
        `CHK("ch2 timeout", 1'b0, ch2_allow)
        ev[7] = 1'b0;
        ev[13] = 1'b0;
        wait_n(4);
        rdc(6'h00, 8'h00);
        `CHK("drive back", 1'b1, drive_en)
        u_host.access(1'b1, 6'h10, 8'h08);
        wait_n(2);
        `CHK("drive soft off", 1'b0, drive_en)
        ev[6] = 1'b0;
        ev[5] = 1'b0;
        ev[8] = 1'b0;
        wait_n(4);
        rdc(6'h01, 8'h22);
        rdc(6'h01, 8'h00);
        // Saturation held across reads, masked off the fault pin
        mask = 16'h0400;
        ev[4] = 1'b1;
        wait_n(4);
        `CHK("fault sat masked", 1'b1, fault_n)
        rdc(6'h01, 8'h04);
        rdc(6'h01, 8'h04);
        ev[4] = 1'b0;
        wait_n(3);
        rdc(6'h01, 8'h04);
        rdc(6'h01, 8'h00);
        mask = 16'h0000;
        // Measurements, revision and unmapped places
        for (int i = 0; i < 3; i++) begin
            temp = 8'($random(seed));
            conv1 = 10'($random(seed));
            conv2 = 10'($random(seed));
            wait_n(1);
            rdc(6'h02, temp);
            rdc(6'h03, {6'h00, conv1[9:8]});
            rdc(6'h04, conv1[7:0]);
            rdc(6'h05, {6'h00, conv2[9:8]});
            rdc(6'h06, conv2[7:0]);
        end
        rdc(6'h0F, REV);
        rdc(6'h07, 8'h00);
        rdc(6'h3F, 8'h00);
        // Every control field value, random unused upper bits
        for (int i = 0; i < 32; i++) begin
            d = {3'($random(seed)), 5'(i)};
            u_host.access(1'b1, 6'h10, d);
            wait_n(1);
            `CHK("ctrl out", d[4:0], ctrl)
            rdc(6'h10, {3'h0, d[4:0]});
        end
        u_host.access(1'b1, 6'h02, 8'hFF);
        rdc(6'h10, {3'h0, d[4:0]});
        wait_n(4);
        report_and_stop();
    end
endmodule
